// file: hdl/ssc_pkg.sv
// constants and types of the sensor-conditioner system control block
// assumes a 125 MHz pclk and a nominal 3 MHz internal oscillator
package ssc_pkg;
  // apb register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_LIMITS = 8'h08;
  localparam logic [7:0] OFS_COEF   = 8'h0C;
  localparam logic [7:0] OFS_RESULT = 8'h10;
  localparam logic [7:0] OFS_OSCINC = 8'h14;
  // field positions
  localparam int LIM_LO_LSB  = 0;
  localparam int LIM_HI_LSB  = 16;
  localparam int COEF_OFS_LSB = 0;
  localparam int COEF_GAIN_LSB = 16;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_MODE_LSB  = 4;
  localparam int ST_FAULT_LSB = 8;
  localparam int GAIN_SHIFT   = 14;
  // reset values
  localparam logic [14:0] LIM_LO_RST = 15'h0000;
  localparam logic [14:0] LIM_HI_RST = 15'h7FFF;
  localparam logic [15:0] OFS_RST    = 16'h0000;
  localparam logic [15:0] GAIN_RST   = 16'h4000;
  localparam logic [15:0] ERR_CODE   = 16'hFFFF;
  // timing: oscillator and pclk rates, durations as printed
  localparam int OSC_KHZ   = 3000;
  localparam int PCLK_KHZ  = 125000;
  localparam int POR_US    = 500;
  localparam int SYS_US    = 200;
  localparam int ROM_MS    = 10;
  localparam int WIN_MS    = 500;
  localparam int START_CONVS = 5;
  localparam int ADC_R_LO  = 13;
  localparam int POR_OSC   = (POR_US * OSC_KHZ + 999) / 1000;
  localparam int SYS_OSC   = SYS_US * OSC_KHZ / 1000;
  localparam int ROM_OSC   = ROM_MS * OSC_KHZ;
  localparam int WIN_OSC   = WIN_MS * OSC_KHZ;
  localparam int CONV_OSC  = 2 ** (ADC_R_LO + 1);
  localparam int WDOG_OSC  = 3000;
  localparam logic [15:0] OSC_INC_RST = 16'(OSC_KHZ * 65536 / PCLK_KHZ);
  localparam int TMR_W     = 24;

  typedef enum logic [1:0] {
    OM_OW_ONLY  = 2'h0,  // one_wire_only_output
    OM_WINDOW   = 2'h1,  // startup_window_output
    OM_ANA_WIN  = 2'h2,  // analog_with_window_output
    OM_OW_DIS   = 2'h3   // one_wire_disabled_output
  } ssc_omode_t;

  typedef enum logic [2:0] {
    ST_POR   = 3'h0,
    ST_SYS   = 3'h1,
    ST_ROM   = 3'h3,
    ST_START = 3'h2,
    ST_WIN   = 3'h6,
    ST_RUN   = 3'h7,
    ST_CMD   = 3'h5,
    ST_DIAG  = 3'h4
  } ssc_state_t;

  typedef enum logic [1:0] {
    WM_NORMAL = 2'h0,  // normal_operation_mode
    WM_CMD    = 2'h1,  // command_mode
    WM_DIAG   = 2'h2   // diagnostic_mode
  } ssc_wmode_t;

  typedef enum logic [1:0] {
    AO_HIZ = 2'h0,
    AO_LOW = 2'h1,       // lower_diagnostic_range
    AO_ANALOG = 2'h2
  } ssc_analog_out_pin_t;

  // application_config_word
  typedef struct packed {
    logic       adc14;
    ssc_omode_t omode;
    logic       rom_check_enable;
  } ssc_ctrl_t;

  localparam ssc_ctrl_t CTRL_RST = '{1'b0, OM_ANA_WIN, 1'b0};

  typedef struct packed {
    logic signature_err;
    logic rom_err;
    logic nvm_err;
    logic ram_err;
    logic sensor_conn;
    logic sensor_short;
    logic temp_sensor;
    logic common_mode;
    logic osc_fail;
  } ssc_fault_t;
endpackage : ssc_pkg

// file: hdl/ssc_osc_tick.sv
// oscillator-rate tick generator: one pulse per internal oscillator period
// assumes the increment is the oscillator/pclk ratio in 1/65536 units
`timescale 1ns/10ps
module ssc_osc_tick (
  input  wire logic        pclk,     // clock
  input  wire logic        presetn,  // async reset, active low
  input  wire logic [15:0] inc,      // phase increment
  output logic             tick      // one-cycle pulse
);
  logic [16:0] acc_r;
  logic [16:0] acc_nxt;

  always_comb
  begin
    acc_nxt = {1'b0, acc_r[15:0]} + {1'b0, inc};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      acc_r <= 17'h00000;
    else
      acc_r <= acc_nxt;
  end

  assign tick = acc_r[16];
endmodule : ssc_osc_tick

// file: hdl/ssc_clip.sv
// clips the conditioned value to the programmed output limits
// assumes lo <= hi; if not, values above hi give hi and all others give lo
`timescale 1ns/10ps
module ssc_clip #(
  parameter int W = 15
) (
  input  wire logic         pclk,     // clock for checks
  input  wire logic         presetn,  // reset for checks
  input  wire logic [W-1:0] val,      // unclipped value
  input  wire logic [W-1:0] lo,       // lower limit
  input  wire logic [W-1:0] hi,       // upper limit
  output logic [W-1:0]      q         // clipped value
);
  always_comb
  begin
    if (val > hi)
      q = hi;
    else if (val < lo)
      q = lo;
    else
      q = val;
  end

  property p_clip_range;
    @(posedge pclk) disable iff (!presetn)
      (lo <= hi) |-> (q <= hi) && (q >= lo) && ((val >= lo && val <= hi) -> q == val);
  endproperty
  a_clip_range: assert property (p_clip_range) else $error("clip out of range");
endmodule : ssc_clip

// file: hdl/ssc_sysctl.sv
// system control sequencer of a bridge-sensor conditioner, apb slave
// assumes a zero-wait apb master and fault inputs synchronous to pclk
`timescale 1ns/10ps
module ssc_sysctl #(
  parameter int ROM_OSC  = ssc_pkg::ROM_OSC,
  parameter int WIN_OSC  = ssc_pkg::WIN_OSC,
  parameter int CONV_OSC = ssc_pkg::CONV_OSC
) (
  input  wire logic               pclk,         // 125 MHz clock
  input  wire logic               presetn,      // async reset, active low
  input  wire logic               psel,         // apb select
  input  wire logic               penable,      // apb enable
  input  wire logic               pwrite,       // apb direction
  input  wire logic [7:0]         paddr,        // apb byte address
  input  wire logic [31:0]        pwdata,       // apb write data
  output logic [31:0]             prdata,       // apb read data
  output logic                    pready,       // apb ready
  output logic                    pslverr,      // apb error
  input  wire logic [15:0]        adc_raw,      // raw bridge conversion
  input  wire logic               adc_valid,    // raw conversion strobe
  input  wire logic               wdg_kick,     // controller watchdog service
  input  wire logic               ow_cmd_enter, // enter_command_mode_cmd seen
  input  wire ssc_pkg::ssc_fault_t fault_in,    // failure detector inputs
  output ssc_pkg::ssc_analog_out_pin_t      analog_out_pin_state,   // analog_out_pin behaviour
  output logic                    analog_out_pin_oe_n,    // pin drive enable, low drives
  output logic [14:0]             dac_value,    // clipped analog value
  output logic                    ow_rd_en,     // one-wire readout allowed
  output logic [15:0]             ow_rd_data,   // one-wire readout word
  output ssc_pkg::ssc_wmode_t     work_mode     // current working mode
);
  initial
  begin
    if (ROM_OSC < 1 || WIN_OSC < 1 || CONV_OSC < 1 ||
        WIN_OSC >= 2 ** ssc_pkg::TMR_W ||
        ROM_OSC >= 2 ** ssc_pkg::TMR_W ||
        2 * ssc_pkg::START_CONVS * CONV_OSC >= 2 ** ssc_pkg::TMR_W)
      $error("ssc_sysctl: timing parameter out of range");
  end

  localparam int TW = ssc_pkg::TMR_W;

  ssc_pkg::ssc_state_t st_r, st_nxt;
  ssc_pkg::ssc_ctrl_t  ctrl_r, ctrl_nxt;
  logic                par_r, par_nxt;
  logic [14:0]         lim_lo_r, lim_lo_nxt, lim_hi_r, lim_hi_nxt;
  logic [15:0]         ofs_r, ofs_nxt, gain_r, gain_nxt;
  logic [15:0]         inc_r, inc_nxt;
  logic [TW-1:0]       tmr_r, tmr_nxt;
  logic [TW-1:0]       tmr_lim;
  logic [15:0]         wdg_r, wdg_nxt;
  logic [10:0]         flt_r, flt_nxt;
  logic [14:0]         res_r, res_nxt;
  logic [14:0]         dac_r, dac_nxt;
  logic [14:0]         clip_q;
  logic [15:0]         corr;
  logic [16:0]         diff;
  logic [32:0]         prod;
  logic                tick;
  logic                tmr_done;
  logic                wdg_fail;
  logic                par_fail;
  logic                any_fault;
  logic                wr_en;
  logic                rd_hit;
  logic [31:0]         rd_mux;

  ssc_osc_tick u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .inc     (inc_r),
    .tick    (tick)
  );

  ssc_clip #(.W(15)) u_clip (
    .pclk    (pclk),
    .presetn (presetn),
    .val     (res_r),
    .lo      (lim_lo_r),
    .hi      (lim_hi_r),
    .q       (clip_q)
  );

  // apb decode, zero wait states
  assign pready = 1'b1;
  assign wr_en  = psel && penable && pwrite;

  always_comb
  begin
    rd_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      ssc_pkg::OFS_CTRL:   rd_mux = {28'h0000000, ctrl_r};
      ssc_pkg::OFS_STATUS: rd_mux = {13'h0000, flt_r, 2'h0, work_mode, 1'b0, st_r};
      ssc_pkg::OFS_LIMITS: rd_mux = {1'b0, lim_hi_r, 1'b0, lim_lo_r};
      ssc_pkg::OFS_COEF:   rd_mux = {gain_r, ofs_r};
      ssc_pkg::OFS_RESULT: rd_mux = {16'h0000, ow_rd_data};
      ssc_pkg::OFS_OSCINC: rd_mux = {16'h0000, inc_r};
      default:             rd_hit = 1'b0;
    endcase
    prdata  = rd_mux;
    pslverr = psel && penable && !rd_hit;
  end

  // configuration registers
  always_comb
  begin
    ctrl_nxt   = ctrl_r;
    par_nxt    = par_r;
    lim_lo_nxt = lim_lo_r;
    lim_hi_nxt = lim_hi_r;
    ofs_nxt    = ofs_r;
    gain_nxt   = gain_r;
    inc_nxt    = inc_r;
    if (wr_en)
    begin
      unique case (paddr)
        ssc_pkg::OFS_CTRL:
        begin
          ctrl_nxt = ssc_pkg::ssc_ctrl_t'(pwdata[3:0]);
          par_nxt  = ^pwdata[3:0];
        end
        ssc_pkg::OFS_LIMITS:
        begin
          lim_lo_nxt = pwdata[ssc_pkg::LIM_LO_LSB +: 15];
          lim_hi_nxt = pwdata[ssc_pkg::LIM_HI_LSB +: 15];
        end
        ssc_pkg::OFS_COEF:
        begin
          ofs_nxt  = pwdata[ssc_pkg::COEF_OFS_LSB +: 16];
          gain_nxt = pwdata[ssc_pkg::COEF_GAIN_LSB +: 16];
        end
        ssc_pkg::OFS_OSCINC: inc_nxt = pwdata[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r   <= ssc_pkg::CTRL_RST;
      par_r    <= ^ssc_pkg::CTRL_RST;
      lim_lo_r <= ssc_pkg::LIM_LO_RST;
      lim_hi_r <= ssc_pkg::LIM_HI_RST;
      ofs_r    <= ssc_pkg::OFS_RST;
      gain_r   <= ssc_pkg::GAIN_RST;
      inc_r    <= ssc_pkg::OSC_INC_RST;
    end
    else
    begin
      ctrl_r   <= ctrl_nxt;
      par_r    <= par_nxt;
      lim_lo_r <= lim_lo_nxt;
      lim_hi_r <= lim_hi_nxt;
      ofs_r    <= ofs_nxt;
      gain_r   <= gain_nxt;
      inc_r    <= inc_nxt;
    end
  end

  // fault collection; sticky until reset
  assign par_fail  = (^ctrl_r) != par_r;
  assign wdg_fail  = wdg_r >= 16'(ssc_pkg::WDOG_OSC);
  assign any_fault = (st_r != ssc_pkg::ST_POR) &&
                     ((|fault_in) || par_fail || wdg_fail);

  always_comb
  begin
    flt_nxt = flt_r;
    wdg_nxt = wdg_r;
    if (st_r != ssc_pkg::ST_POR)
      flt_nxt = flt_r | {wdg_fail, par_fail, fault_in};
    if (wdg_kick || st_r == ssc_pkg::ST_POR)
      wdg_nxt = 16'h0000;
    else if (tick && !wdg_fail)
      wdg_nxt = wdg_r + 16'h0001;
  end

  // correction and conditioned result
  always_comb
  begin
    diff = {1'b0, adc_raw} - {1'b0, ofs_r};
    prod = {16'h0000, diff} * {17'h00000, gain_r};
    if (diff[16])
      corr = 16'h0000;
    else if (|prod[32:ssc_pkg::GAIN_SHIFT + 16])
      corr = 16'hFFFF;
    else
      corr = prod[ssc_pkg::GAIN_SHIFT +: 16];
    res_nxt = res_r;
    if (adc_valid && (st_r == ssc_pkg::ST_RUN || st_r == ssc_pkg::ST_WIN ||
                      st_r == ssc_pkg::ST_CMD))
      res_nxt = corr[15] ? 15'h7FFF : corr[14:0];
    dac_nxt = clip_q;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flt_r <= 11'h000;
      wdg_r <= 16'h0000;
      res_r <= 15'h0000;
      dac_r <= 15'h0000;
    end
    else
    begin
      flt_r <= flt_nxt;
      wdg_r <= wdg_nxt;
      res_r <= res_nxt;
      dac_r <= dac_nxt;
    end
  end

  // startup sequencer, durations counted in oscillator ticks
  always_comb
  begin
    unique case (st_r)
      ssc_pkg::ST_POR:   tmr_lim = TW'(ssc_pkg::POR_OSC);
      ssc_pkg::ST_SYS:   tmr_lim = TW'(ssc_pkg::SYS_OSC);
      ssc_pkg::ST_ROM:   tmr_lim = TW'(ROM_OSC);
      ssc_pkg::ST_START: tmr_lim = TW'(ssc_pkg::START_CONVS * CONV_OSC) <<
                                   ctrl_r.adc14;
      ssc_pkg::ST_WIN:   tmr_lim = TW'(WIN_OSC);
      default:           tmr_lim = '1;
    endcase
  end

  assign tmr_done = tick && (tmr_r >= tmr_lim - TW'(1));

  always_comb
  begin
    st_nxt = st_r;
    unique case (st_r)
      ssc_pkg::ST_POR:
        if (tmr_done)
          st_nxt = ssc_pkg::ST_SYS;
      ssc_pkg::ST_SYS:
        if (tmr_done)
          st_nxt = ctrl_r.rom_check_enable ? ssc_pkg::ST_ROM : ssc_pkg::ST_START;
      ssc_pkg::ST_ROM:
        if (tmr_done)
          st_nxt = ssc_pkg::ST_START;
      ssc_pkg::ST_START:
        if (tmr_done)
          st_nxt = (ctrl_r.omode == ssc_pkg::OM_WINDOW ||
                    ctrl_r.omode == ssc_pkg::OM_ANA_WIN) ?
                   ssc_pkg::ST_WIN : ssc_pkg::ST_RUN;
      ssc_pkg::ST_WIN:
        if (ow_cmd_enter)
          st_nxt = ssc_pkg::ST_CMD;
        else if (tmr_done)
          st_nxt = ssc_pkg::ST_RUN;
      ssc_pkg::ST_RUN, ssc_pkg::ST_CMD, ssc_pkg::ST_DIAG: ;
      default: st_nxt = ssc_pkg::ST_DIAG;
    endcase
    if (any_fault)
      st_nxt = ssc_pkg::ST_DIAG;
    tmr_nxt = (st_nxt != st_r) ? '0 : (tick ? tmr_r + TW'(1) : tmr_r);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r  <= ssc_pkg::ST_POR;
      tmr_r <= '0;
    end
    else
    begin
      st_r  <= st_nxt;
      tmr_r <= tmr_nxt;
    end
  end

  // working mode and pin behaviour
  always_comb
  begin
    unique case (st_r)
      ssc_pkg::ST_CMD:  work_mode = ssc_pkg::WM_CMD;
      ssc_pkg::ST_DIAG: work_mode = ssc_pkg::WM_DIAG;
      default:          work_mode = ssc_pkg::WM_NORMAL;
    endcase
    unique case (st_r)
      ssc_pkg::ST_POR:  analog_out_pin_state = ssc_pkg::AO_HIZ;
      ssc_pkg::ST_SYS,
      ssc_pkg::ST_ROM,
      ssc_pkg::ST_DIAG: analog_out_pin_state = ssc_pkg::AO_LOW;
      ssc_pkg::ST_START:
        analog_out_pin_state = (ctrl_r.omode == ssc_pkg::OM_ANA_WIN ||
                      ctrl_r.omode == ssc_pkg::OM_OW_DIS) ?
                     ssc_pkg::AO_LOW : ssc_pkg::AO_HIZ;
      ssc_pkg::ST_WIN:
        analog_out_pin_state = (ctrl_r.omode == ssc_pkg::OM_ANA_WIN) ?
                     ssc_pkg::AO_ANALOG : ssc_pkg::AO_HIZ;
      ssc_pkg::ST_RUN:
        analog_out_pin_state = (ctrl_r.omode == ssc_pkg::OM_OW_ONLY) ?
                     ssc_pkg::AO_HIZ : ssc_pkg::AO_ANALOG;
      default: analog_out_pin_state = ssc_pkg::AO_HIZ;
    endcase
  end

  assign analog_out_pin_oe_n   = (analog_out_pin_state == ssc_pkg::AO_HIZ);
  assign dac_value   = dac_r;
  assign ow_rd_en    = (ctrl_r.omode != ssc_pkg::OM_OW_DIS) &&
                       (st_r == ssc_pkg::ST_RUN || st_r == ssc_pkg::ST_CMD ||
                        st_r == ssc_pkg::ST_DIAG);
  assign ow_rd_data  = (st_r == ssc_pkg::ST_DIAG) ?
                       ssc_pkg::ERR_CODE : {1'b0, res_r};

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_por_hiz;
    st_r == ssc_pkg::ST_POR |-> analog_out_pin_state == ssc_pkg::AO_HIZ && analog_out_pin_oe_n;
  endproperty
  a_por_hiz: assert property (p_por_hiz) else $error("pin driven in reset hold");

  property p_sys_low;
    st_r == ssc_pkg::ST_SYS |-> analog_out_pin_state == ssc_pkg::AO_LOW;
  endproperty
  a_sys_low: assert property (p_sys_low) else $error("pin not low in system start");

  property p_rom_path;
    $past(st_r) == ssc_pkg::ST_SYS && st_r != ssc_pkg::ST_SYS &&
      st_r != ssc_pkg::ST_DIAG |->
      st_r == ($past(ctrl_r.rom_check_enable) ? ssc_pkg::ST_ROM : ssc_pkg::ST_START);
  endproperty
  a_rom_path: assert property (p_rom_path) else $error("rom check step wrong");

  property p_start_pin;
    st_r == ssc_pkg::ST_START && ctrl_r.omode[1] |-> analog_out_pin_state == ssc_pkg::AO_LOW;
  endproperty
  a_start_pin: assert property (p_start_pin) else $error("start routine pin wrong");

  sequence s_fault;
    any_fault;
  endsequence
  sequence s_diag_low;
    st_r == ssc_pkg::ST_DIAG ##0 analog_out_pin_state == ssc_pkg::AO_LOW;
  endsequence
  property p_fault_diag;
    s_fault |=> s_diag_low;
  endproperty
  a_fault_diag: assert property (p_fault_diag) else $error("fault missed diag");

  property p_diag_code;
    work_mode == ssc_pkg::WM_DIAG |-> ow_rd_data == ssc_pkg::ERR_CODE;
  endproperty
  a_diag_code: assert property (p_diag_code) else $error("no error code in diag");

  property p_cmd_entry;
    st_r == ssc_pkg::ST_WIN && ow_cmd_enter && !any_fault |=>
      st_r == ssc_pkg::ST_CMD ##1 analog_out_pin_state != ssc_pkg::AO_ANALOG;
  endproperty
  a_cmd_entry: assert property (p_cmd_entry) else $error("command entry lost");

  property p_win_hold;
    st_r == ssc_pkg::ST_WIN && ctrl_r.omode == ssc_pkg::OM_WINDOW |->
      analog_out_pin_state != ssc_pkg::AO_ANALOG;
  endproperty
  a_win_hold: assert property (p_win_hold) else $error("analog before window end");

  property p_ow_dis;
    ctrl_r.omode == ssc_pkg::OM_OW_DIS |-> !ow_rd_en;
  endproperty
  a_ow_dis: assert property (p_ow_dis) else $error("one-wire readout not refused");
endmodule : ssc_sysctl

// file: tb/ssc_owi_master.sv
// far-side one-wire master model: sends the enter-command frame on request
// assumes the bench pulses send for one pclk cycle, inside the startup window or after it
`timescale 1ns/10ps
module ssc_ow_master (
  input  wire logic pclk,      // clock
  input  wire logic presetn,   // async reset, active low
  input  wire logic send,      // request one command frame
  output logic      cmd_enter  // decoded command towards the device
);
  logic cmd_r;
  logic cmd_nxt;

  // the send request is registered, so cmd_enter follows send one pclk cycle later
  always_comb
  begin
    cmd_nxt = send;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_r <= 1'b0;
    end
    else
    begin
      cmd_r <= cmd_nxt;
    end
  end

  assign cmd_enter = cmd_r;
endmodule : ssc_ow_master

// file: tb/ssc_sysctl_test.sv
// self-checking bench of the system control sequencer
// assumes shortened startup counts and a fast oscillator tick set over apb
`timescale 1ns/10ps
module ssc_sysctl_test;
  logic                pclk = 1'b0;
  logic                presetn = 1'b0;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic [7:0]          paddr = 8'h00;
  logic [31:0]         pwdata = 32'h0;
  logic [15:0]         adc_raw = 16'h0;
  logic                adc_valid = 1'b0;
  logic                wdg_kick = 1'b0;
  logic                kick_en = 1'b1;
  logic                send = 1'b0;
  ssc_pkg::ssc_fault_t fault_in = '0;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic                ow_cmd_enter;
  ssc_pkg::ssc_analog_out_pin_t  analog_out_pin_state;
  logic                analog_out_pin_oe_n;
  logic [14:0]         dac_value;
  logic                ow_rd_en;
  logic [15:0]         ow_rd_data;
  ssc_pkg::ssc_wmode_t work_mode;
  logic [31:0]         rd;
  logic                err;
  int                  miscompares = 0;
  int                  n_checks = 0;

  always #4 pclk = ~pclk;

  always @(posedge pclk) wdg_kick <= kick_en;

  ssc_sysctl #(.ROM_OSC(20), .WIN_OSC(40), .CONV_OSC(4)) ssc_sysctl_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .adc_raw(adc_raw), .adc_valid(adc_valid),
    .wdg_kick(wdg_kick), .ow_cmd_enter(ow_cmd_enter), .fault_in(fault_in),
    .analog_out_pin_state(analog_out_pin_state), .analog_out_pin_oe_n(analog_out_pin_oe_n), .dac_value(dac_value),
    .ow_rd_en(ow_rd_en), .ow_rd_data(ow_rd_data), .work_mode(work_mode));

  ssc_ow_master ssc_ow_master_inst (
    .pclk(pclk), .presetn(presetn), .send(send), .cmd_enter(ow_cmd_enter));

  task automatic final_report();
    if (miscompares == 0 && n_checks > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_st(input ssc_pkg::ssc_state_t s);
    for (int i = 0; i < 1200; i++)
    begin
      apb(1'b0, ssc_pkg::OFS_STATUS, 32'h0);
      if (rd[2:0] === s) break;
    end
    chk("state", 32'(s), {29'h0, rd[2:0]});
    @(negedge pclk);
  endtask : wait_st

  task automatic start(input logic [31:0] ctrl);
    @(posedge pclk);
    presetn <= 1'b0;
    fault_in <= '0;
    kick_en <= 1'b1;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("por analog_out_pin", 32'(ssc_pkg::AO_HIZ), 32'(analog_out_pin_state));
    chk("por oe_n", 32'h1, 32'(analog_out_pin_oe_n));
    if (ctrl !== 32'hFFFFFFFF) apb(1'b1, ssc_pkg::OFS_OSCINC, 32'h0000FFFF);
    if (ctrl !== 32'hFFFFFFFF) apb(1'b1, ssc_pkg::OFS_CTRL, ctrl);
  endtask : start

  task automatic t_regs();
    logic [7:0]  a [5] = '{8'h00, 8'h08, 8'h0C, 8'h14, 8'h20};
    logic [31:0] e [5] = '{32'h4, 32'h7FFF0000, 32'h40000000, 32'h624, 32'h0};
    start(32'hFFFFFFFF);
    chk("pready", 32'h1, 32'(pready));
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, a[i], 32'h0);
      chk("reg", e[i], rd);
      chk("slverr", 32'(i == 4), 32'(err));
    end
    apb(1'b0, ssc_pkg::OFS_RESULT, 32'h0);
    chk("result", 32'h0, rd);
  endtask : t_regs

  task automatic t_mode(input logic [31:0] ctrl, input ssc_pkg::ssc_analog_out_pin_t sa,
                        input ssc_pkg::ssc_analog_out_pin_t wa, input ssc_pkg::ssc_analog_out_pin_t ra,
                        input logic en);
    start(ctrl);
    wait_st(ssc_pkg::ST_SYS);
    chk("sys analog_out_pin", 32'(ssc_pkg::AO_LOW), 32'(analog_out_pin_state));
    wait_st(ssc_pkg::ST_START);
    chk("start analog_out_pin", 32'(sa), 32'(analog_out_pin_state));
    if (ctrl[2:1] == 2'h1 || ctrl[2:1] == 2'h2)
    begin
      wait_st(ssc_pkg::ST_WIN);
      chk("win analog_out_pin", 32'(wa), 32'(analog_out_pin_state));
    end
    wait_st(ssc_pkg::ST_RUN);
    chk("run analog_out_pin", 32'(ra), 32'(analog_out_pin_state));
    chk("run oe_n", 32'(ra == ssc_pkg::AO_HIZ), 32'(analog_out_pin_oe_n));
    chk("rd_en", 32'(en), 32'(ow_rd_en));
    chk("mode", 32'(ssc_pkg::WM_NORMAL), 32'(work_mode));
  endtask : t_mode

  task automatic sample(input logic [15:0] raw, input logic [15:0] er, input logic [14:0] ed);
    @(posedge pclk);
    adc_raw <= raw;
    adc_valid <= 1'b1;
    @(posedge pclk);
    adc_valid <= 1'b0;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk("rd_data", 32'(er), 32'(ow_rd_data));
    chk("dac", 32'(ed), 32'(dac_value));
  endtask : sample

  task automatic t_meas();
    apb(1'b1, ssc_pkg::OFS_LIMITS, 32'h10000100);
    sample(16'h1234, 16'h1234, 15'h1000);
    apb(1'b1, ssc_pkg::OFS_COEF, 32'h80000034);
    sample(16'h0040, 16'h0018, 15'h0100);
    sample(16'h5000, 16'h7FFF, 15'h1000);
  endtask : t_meas

  task automatic t_cmd(input logic [31:0] ctrl, input logic late);
    start(ctrl);
    wait_st(late ? ssc_pkg::ST_RUN : ssc_pkg::ST_WIN);
    @(posedge pclk);
    send <= 1'b1;
    @(posedge pclk);
    send <= 1'b0;
    repeat (3) @(posedge pclk);
    apb(1'b0, ssc_pkg::OFS_STATUS, 32'h0);
    @(negedge pclk);
    chk("cmd state", 32'(late ? ssc_pkg::ST_RUN : ssc_pkg::ST_CMD), {29'h0, rd[2:0]});
    chk("cmd mode", 32'(late ? ssc_pkg::WM_NORMAL : ssc_pkg::WM_CMD), 32'(work_mode));
    chk("cmd analog_out_pin", 32'(late ? ssc_pkg::AO_ANALOG : ssc_pkg::AO_HIZ), 32'(analog_out_pin_state));
  endtask : t_cmd

  task automatic t_rom();
    start(32'hF);
    wait_st(ssc_pkg::ST_ROM);
    chk("rom analog_out_pin", 32'(ssc_pkg::AO_LOW), 32'(analog_out_pin_state));
    apb(1'b0, ssc_pkg::OFS_CTRL, 32'h0);
    chk("ctrl", 32'hF, rd);
    wait_st(ssc_pkg::ST_START);
    chk("rom start analog_out_pin", 32'(ssc_pkg::AO_LOW), 32'(analog_out_pin_state));
    wait_st(ssc_pkg::ST_RUN);
  endtask : t_rom

  task automatic t_fault(input int b, input logic [2:0] st, input int dly);
    start(32'h6);
    wait_st(ssc_pkg::ssc_state_t'(st));
    @(posedge pclk);
    if (b < 9) fault_in <= ssc_pkg::ssc_fault_t'(9'h1 << b);
    if (b == 10) kick_en <= 1'b0;
    repeat (dly) @(posedge pclk);
    @(negedge pclk);
    chk("diag mode", 32'(ssc_pkg::WM_DIAG), 32'(work_mode));
    chk("diag analog_out_pin", 32'(ssc_pkg::AO_LOW), 32'(analog_out_pin_state));
    chk("diag data", 32'hFFFF, 32'(ow_rd_data));
    apb(1'b0, ssc_pkg::OFS_STATUS, 32'h0);
    chk("sticky", 32'h1 << (b + 8), rd & 32'h7FF00);
  endtask : t_fault

  initial
  begin
    #640000;
    miscompares++;
    final_report();
  end

  initial
  begin
    t_regs();
    t_mode(32'h0, ssc_pkg::AO_HIZ, ssc_pkg::AO_HIZ, ssc_pkg::AO_HIZ, 1'b1);
    t_mode(32'h2, ssc_pkg::AO_HIZ, ssc_pkg::AO_HIZ, ssc_pkg::AO_ANALOG, 1'b1);
    t_mode(32'h6, ssc_pkg::AO_LOW, ssc_pkg::AO_HIZ, ssc_pkg::AO_ANALOG, 1'b0);
    t_mode(32'h4, ssc_pkg::AO_LOW, ssc_pkg::AO_ANALOG, ssc_pkg::AO_ANALOG, 1'b1);
    t_meas();
    t_cmd(32'h2, 1'b0);
    t_cmd(32'h4, 1'b0);
    t_cmd(32'h2, 1'b1);
    t_rom();
    t_fault(4, 3'(ssc_pkg::ST_SYS), 2);
    for (int i = 0; i < 9; i++) t_fault(i, 3'(ssc_pkg::ST_RUN), 2);
    t_fault(10, 3'(ssc_pkg::ST_RUN), 3100);
    final_report();
  end
endmodule : ssc_sysctl_test
